// file: verilog/sfr_cmd_core.sv
// serial flash command core: array reads, buffer read/write, buffer
// program with erase; holds the array and both buffers itself
// assumes sclk runs only inside frames and csB frames every command
`timescale 1ns/10ps
module sfr_cmd_core #(
  parameter int unsigned epCycles = sfr_pkg::EP_CYCLES
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // page size strap, high selects 528-byte pages
  input wire logic pageSize528,
  // serial link
  input wire logic sclk,
  input wire logic csB,
  input wire logic serIn,
  output logic serOut,
  output logic serOutOeB,
  // status flags
  output sfr_pkg::sfr_status_t status
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] flashMem [sfr_pkg::MEM_BYTES];
  logic [7:0] bufMem [2][sfr_pkg::PAGE_BYTES_EXT];

  // flat array index for a page and byte, always on a 528-byte pitch
  function automatic logic [21:0] flatIdx(input logic [11:0] pg, input logic [9:0] by);
    flatIdx = 22'(pg) * 22'(sfr_pkg::PAGE_BYTES_EXT) + 22'(by);
  endfunction

  // ----------------------------------------------------------------
  // link reset hand-off
  // ----------------------------------------------------------------
  logic linkRstB_q;
  logic frameClr;

  // registered copy of reset, used as async clear on the link side
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      linkRstB_q <= 1'b0;
    end else begin
      linkRstB_q <= 1'b1;
    end
  end

  // a frame ends on chip select high, so link state needs no edge after it
  assign frameClr = csB | ~linkRstB_q;

  // ----------------------------------------------------------------
  // link side: per-frame state and persistent state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_DUMMY, PH_RDATA, PH_WDATA, PH_IGNORE} sfr_phase_t;

  sfr_phase_t phase_q;
  logic [5:0] bitCnt_q;
  logic [7:0] opc_q;
  logic [23:0] addrSr_q;
  logic [2:0] dataBit_q;
  logic [7:0] curByte_q;
  logic [11:0] rdPage_q;
  logic [9:0] rdByte_q;
  logic [6:0] wrSr_q;
  logic [2:0] lnkPgSync_q;
  logic lnkPg528_q;
  logic pgmTgl_q;
  sfr_pkg::sfr_pgm_t pgmCmd_q;

  logic [7:0] opcNext;
  logic [23:0] addrNext;
  logic isCont, isPageRd, isBufRd, isBufRdHf, isBufWr, isPgm, bufSel, isKnown;
  logic [9:0] lastByte;
  logic [11:0] startPage, nextPage, fetchPage;
  logic [9:0] startByte, nextByte, fetchByte;
  logic [7:0] fetchData;
  logic addrDone, bufWe;

  assign opcNext = {opc_q[6:0], serIn};
  assign addrNext = {addrSr_q[22:0], serIn};

  // opcode decode; during the opcode phase look at the byte being completed
  always_comb begin
    logic [7:0] op;
    op = (phase_q == PH_OPC) ? opcNext : opc_q;
    isCont = (op == sfr_pkg::OP_READ_LOWPWR);
    isPageRd = (op == sfr_pkg::OP_READ_PAGE);
    isBufRdHf = (op == sfr_pkg::OP_BUF1_READ_HF) || (op == sfr_pkg::OP_BUF2_READ_HF);
    isBufRd = isBufRdHf || (op == sfr_pkg::OP_BUF1_READ_LF) ||
              (op == sfr_pkg::OP_BUF2_READ_LF);
    isBufWr = (op == sfr_pkg::OP_BUF1_WRITE) || (op == sfr_pkg::OP_BUF2_WRITE);
    isPgm = (op == sfr_pkg::OP_BUF1_PGM_ERASE) || (op == sfr_pkg::OP_BUF2_PGM_ERASE);
    bufSel = (op == sfr_pkg::OP_BUF2_READ_HF) || (op == sfr_pkg::OP_BUF2_READ_LF) ||
             (op == sfr_pkg::OP_BUF2_WRITE) || (op == sfr_pkg::OP_BUF2_PGM_ERASE);
    isKnown = isCont || isPageRd || isBufRd || isBufWr || isPgm;
  end

  assign lastByte = lnkPg528_q ? sfr_pkg::LAST_EXT : sfr_pkg::LAST_STD;
  assign addrDone = (phase_q == PH_ADDR) && (bitCnt_q == sfr_pkg::ADDR_LAST_BIT);

  // start position from the completed address
  always_comb begin
    logic [9:0] rawByte;
    rawByte = 10'h000;
    // 528 split: 12 page bits then 10 byte bits
    if (lnkPg528_q) begin
      startPage = addrNext[sfr_pkg::EXT_PAGE_LSB +: 12];
      rawByte = addrNext[9:0];
    // 512 split: 12 page bits then nine byte bits
    end else begin
      startPage = addrNext[sfr_pkg::STD_PAGE_LSB +: 12];
      rawByte = {1'b0, addrNext[8:0]};
    end
    // buffer offset shares the low bits; out-of-range offsets start at zero
    startByte = (rawByte > lastByte) ? 10'h000 : rawByte;
  end

  // next position after a whole byte
  always_comb begin
    nextPage = rdPage_q;
    nextByte = rdByte_q + 10'h001;
    if (rdByte_q == lastByte) begin
      nextByte = 10'h000;
      // next page, 12-bit page count wraps to page zero
      if (isCont) begin
        nextPage = rdPage_q + 12'h001;
      end
      // page read and buffer read stay put and wrap
    end
  end

  // fetch mux: start at address end, held position after dummies, else next
  always_comb begin
    if (phase_q == PH_ADDR) begin
      fetchPage = startPage;
      fetchByte = startByte;
    end else if (phase_q == PH_DUMMY) begin
      fetchPage = rdPage_q;
      fetchByte = rdByte_q;
    end else begin
      fetchPage = nextPage;
      fetchByte = nextByte;
    end
  end

  // array reads go straight to the array, buffers only for buffer reads
  assign fetchData = isBufRd ? bufMem[bufSel][fetchByte] : flashMem[flatIdx(fetchPage, fetchByte)];

  // frame sequencer on the serial clock, cleared by chip select high
  always_ff @(posedge sclk or posedge frameClr) begin
    if (frameClr) begin
      phase_q <= PH_OPC;
      bitCnt_q <= 6'h00;
      opc_q <= 8'h00;
      addrSr_q <= 24'h000000;
      dataBit_q <= 3'h0;
      curByte_q <= 8'h00;
      rdPage_q <= 12'h000;
      rdByte_q <= 10'h000;
      wrSr_q <= 7'h00;
    end else begin
      unique case (phase_q)
        PH_OPC: begin
          opc_q <= opcNext;
          bitCnt_q <= bitCnt_q + 6'h01;
          if (bitCnt_q == sfr_pkg::OPC_LAST_BIT) begin
            bitCnt_q <= 6'h00;
            phase_q <= isKnown ? PH_ADDR : PH_IGNORE;
          end
        end
        PH_ADDR: begin
          addrSr_q <= addrNext;
          bitCnt_q <= bitCnt_q + 6'h01;
          if (addrDone) begin
            bitCnt_q <= 6'h00;
            rdPage_q <= startPage;
            rdByte_q <= startByte;
            dataBit_q <= 3'h0;
            if (isPgm) begin
              phase_q <= PH_IGNORE;
            end else if (isBufWr) begin
              phase_q <= PH_WDATA;
            // page read and fast buffer read take dummies first
            end else if (isPageRd || isBufRdHf) begin
              phase_q <= PH_DUMMY;
            // no dummies, first byte ready for the next clock
            end else begin
              phase_q <= PH_RDATA;
              curByte_q <= fetchData;
            end
          end
        end
        PH_DUMMY: begin
          bitCnt_q <= bitCnt_q + 6'h01;
          // four dummy bytes, one dummy byte
          if (bitCnt_q == (isPageRd ? sfr_pkg::PAGE_RD_DUMMY_LAST : sfr_pkg::BUF_RD_DUMMY_LAST)) begin
            phase_q <= PH_RDATA;
            curByte_q <= fetchData;
          end
        end
        PH_RDATA: begin
          dataBit_q <= dataBit_q + 3'h1;
          // next byte loaded on the last bit edge, so no gap
          if (dataBit_q == sfr_pkg::BYTE_LAST_BIT) begin
            rdPage_q <= nextPage;
            rdByte_q <= nextByte;
            curByte_q <= fetchData;
          end
        end
        PH_WDATA: begin
          wrSr_q <= {wrSr_q[5:0], serIn};
          dataBit_q <= dataBit_q + 3'h1;
          // advance and wrap the buffer offset per byte
          if (dataBit_q == sfr_pkg::BYTE_LAST_BIT) begin
            rdByte_q <= nextByte;
          end
        end
        PH_IGNORE: begin
          bitCnt_q <= 6'h00;
        end
      endcase
    end
  end

  // load bytes until chip select clears the phase
  assign bufWe = (phase_q == PH_WDATA) && (dataBit_q == sfr_pkg::BYTE_LAST_BIT) && !frameClr;

  // buffer write storage; a trailing partial byte is dropped
  always_ff @(posedge sclk) begin
    if (bufWe) begin
      bufMem[bufSel][rdByte_q] <= {wrSr_q, serIn};
    end
  end

  // strap sync and program hand-off, kept across frames
  always_ff @(posedge sclk or negedge linkRstB_q) begin
    if (!linkRstB_q) begin
      lnkPgSync_q <= 3'h0;
      lnkPg528_q <= 1'b0;
      pgmTgl_q <= 1'b0;
      pgmCmd_q <= '0;
    end else begin
      lnkPgSync_q <= {lnkPgSync_q[1:0], pageSize528};
      if (lnkPgSync_q[1] == lnkPgSync_q[2]) begin
        lnkPg528_q <= lnkPgSync_q[2];
      end
      // page field sits where the array read page field does
      if (addrDone && isPgm && !csB) begin
        pgmCmd_q.page <= startPage;
        pgmCmd_q.bufSel <= bufSel;
        pgmTgl_q <= ~pgmTgl_q;
      end
    end
  end

  // output floats the moment chip select rises
  always_ff @(negedge sclk or posedge frameClr) begin
    if (frameClr) begin
      serOut <= 1'b0;
      serOutOeB <= 1'b1;
    end else if (phase_q == PH_RDATA) begin
      serOut <= curByte_q[~dataBit_q];
      serOutOeB <= 1'b0;
    end else begin
      serOut <= 1'b0;
      serOutOeB <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // core side: synchronisers
  // ----------------------------------------------------------------
  logic [2:0] csSync_q, pgmSync_q, pgSzSync_q;
  logic csHigh_q, pgmSeen_q, pg528_q;

  // three stages; stage 0 feeds stage 1 only
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      csSync_q <= 3'h7;
      pgmSync_q <= 3'h0;
      pgSzSync_q <= 3'h0;
      csHigh_q <= 1'b1;
      pg528_q <= 1'b0;
    end else begin
      csSync_q <= {csSync_q[1:0], csB};
      pgmSync_q <= {pgmSync_q[1:0], pgmTgl_q};
      pgSzSync_q <= {pgSzSync_q[1:0], pageSize528};
      if (csSync_q[1] == csSync_q[2]) begin
        csHigh_q <= csSync_q[2];
      end
      if (pgSzSync_q[1] == pgSzSync_q[2]) begin
        pg528_q <= pgSzSync_q[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // core side: erase and program sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_VERIFY, ST_HOLD} sfr_state_t;

  sfr_state_t state_q;
  sfr_pkg::sfr_pgm_t job_q;
  logic [9:0] idx_q;
  logic [31:0] timer_q;
  logic start, idxLast, memWe, fail;
  logic [21:0] memAddr;
  logic [7:0] memWd, bufRd;

  // start only once the frame has closed and the toggle has settled
  assign start = (state_q == ST_IDLE) && csHigh_q && (pgmSync_q[1] == pgmSync_q[2]) &&
                 (pgmSync_q[2] != pgmSeen_q);
  assign idxLast = idx_q == (pg528_q ? sfr_pkg::LAST_EXT : sfr_pkg::LAST_STD);
  assign memAddr = flatIdx(job_q.page, idx_q);
  assign bufRd = bufMem[job_q.bufSel][idx_q];

  // erase writes ones, program copies the buffer
  always_comb begin
    memWe = (state_q == ST_ERASE) || (state_q == ST_PROG);
    memWd = (state_q == ST_ERASE) ? sfr_pkg::ERASED_BYTE : bufRd;
  end

  // programming checks the erase result, verify checks the program
  always_comb begin
    fail = 1'b0;
    if (state_q == ST_PROG) begin
      fail = flashMem[memAddr] != sfr_pkg::ERASED_BYTE;
    end else if (state_q == ST_VERIFY) begin
      fail = flashMem[memAddr] != bufRd;
    end
  end

  // array write port
  always_ff @(posedge core_clk) begin
    if (memWe) begin
      flashMem[memAddr] <= memWd;
    end
  end

  // sequencer; busy holds for the full erase_program_time window
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      job_q <= '0;
      idx_q <= 10'h000;
      timer_q <= 32'h00000000;
      pgmSeen_q <= 1'b0;
    end else begin
      timer_q <= (state_q == ST_IDLE) ? 32'h00000000 : timer_q + 32'h00000001;
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            job_q <= pgmCmd_q;
            pgmSeen_q <= pgmSync_q[2];
            idx_q <= 10'h000;
            state_q <= ST_ERASE;
          end
        end
        ST_ERASE, ST_PROG, ST_VERIFY: begin
          idx_q <= idx_q + 10'h001;
          if (idxLast) begin
            idx_q <= 10'h000;
            state_q <= (state_q == ST_ERASE) ? ST_PROG :
                       (state_q == ST_PROG) ? ST_VERIFY : ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (timer_q >= epCycles - 1) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // status flags; error is cleared only by reset or by the next job
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      status <= '0;
    end else begin
      // busy from start to end of the hold
      if (start) begin
        status.busy <= 1'b1;
      end else if (state_q == ST_HOLD && timer_q >= epCycles - 1) begin
        status.busy <= 1'b0;
      end
      // sticky error for the current job
      if (start) begin
        status.eraseProgramErrorFlag <= 1'b0;
      end else if (fail) begin
        status.eraseProgramErrorFlag <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence sq_jobStart;
    start;
  endsequence

  sequence sq_eraseRun;
    (state_q == ST_ERASE) && memWe && (memWd == sfr_pkg::ERASED_BYTE) && status.busy;
  endsequence

  a_next_page_cont: assert property (@(posedge sclk) disable iff (frameClr)
    (phase_q == PH_RDATA && isCont && dataBit_q == sfr_pkg::BYTE_LAST_BIT &&
     rdByte_q == lastByte && rdPage_q != sfr_pkg::PAGE_LAST) |=>
    (rdByte_q == 10'h000 && rdPage_q == $past(rdPage_q) + 12'h001 && dataBit_q == 3'h0))
    else $error("continuous read did not roll to next page");

  a_array_wrap: assert property (@(posedge sclk) disable iff (frameClr)
    (phase_q == PH_RDATA && isCont && dataBit_q == sfr_pkg::BYTE_LAST_BIT &&
     rdByte_q == lastByte && rdPage_q == sfr_pkg::PAGE_LAST) |=>
    (rdByte_q == 10'h000 && rdPage_q == 12'h000))
    else $error("continuous read did not wrap to first page");

  a_page_rd_wrap: assert property (@(posedge sclk) disable iff (frameClr)
    (phase_q == PH_RDATA && isPageRd && dataBit_q == sfr_pkg::BYTE_LAST_BIT &&
     rdByte_q == lastByte) |=> (rdByte_q == 10'h000 && $stable(rdPage_q)))
    else $error("page read left its page");

  a_buf_rd_wrap: assert property (@(posedge sclk) disable iff (frameClr)
    (phase_q == PH_RDATA && isBufRd && dataBit_q == sfr_pkg::BYTE_LAST_BIT &&
     rdByte_q == lastByte) |=> rdByte_q == 10'h000)
    else $error("buffer read did not wrap to zero");

  a_buf_wr_wrap: assert property (@(posedge sclk) disable iff (frameClr)
    (bufWe && rdByte_q == lastByte) |=> (rdByte_q == 10'h000 && phase_q == PH_WDATA))
    else $error("buffer write did not wrap to zero");

  a_bufs_untouched: assert property (@(posedge sclk) disable iff (frameClr)
    bufWe |-> (isBufWr && !isCont && !isPageRd))
    else $error("buffer written outside buffer write");

  a_page_rd_dummy: assert property (@(posedge sclk) disable iff (frameClr)
    (addrDone && isPageRd) |=> (phase_q == PH_DUMMY) ##32 (phase_q == PH_RDATA))
    else $error("page read dummy count wrong");

  a_fast_buf_dummy: assert property (@(posedge sclk) disable iff (frameClr)
    (addrDone && isBufRdHf) |=> (phase_q == PH_DUMMY) ##8 (phase_q == PH_RDATA))
    else $error("fast buffer read dummy count wrong");

  a_tristate_cs: assert property (@(posedge core_clk) disable iff (!rst_b)
    csHigh_q |-> (serOutOeB && phase_q == PH_OPC))
    else $error("output driven with chip select high");

  a_pgm_start: assert property (@(posedge core_clk) disable iff (!rst_b)
    sq_jobStart |=> sq_eraseRun ##1 (state_q == ST_ERASE))
    else $error("program job did not begin with erase");

  a_busy_running: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_q != ST_IDLE) |-> (status.busy && timer_q < epCycles + 32'h00000001))
    else $error("busy flag low during job");

  a_error_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    fail |=> status.eraseProgramErrorFlag)
    else $error("failed byte not flagged");

endmodule

// file: verilog/sfr_pkg.sv
// constants, opcodes and carrier types for the serial flash command core
// assumes one core clock at 100 MHz and a host-driven serial clock
package sfr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int EP_TIME_US = 20000; // erase_program_time, upper bound
  localparam int EP_CYCLES = EP_TIME_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int PAGE_COUNT = 4096;
  localparam int PAGE_BYTES_STD = 512;
  localparam int PAGE_BYTES_EXT = 528;
  localparam int MEM_BYTES = PAGE_COUNT * PAGE_BYTES_EXT;
  localparam int EXT_PAGE_LSB = 10;
  localparam int STD_PAGE_LSB = 9;
  localparam logic [11:0] PAGE_LAST = 12'hfff;
  localparam logic [9:0] LAST_STD = 10'h1ff;
  localparam logic [9:0] LAST_EXT = 10'h20f;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ----------------------------------------------------------------
  // serial frame bit counts
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_LAST_BIT = 6'h07;
  localparam logic [5:0] ADDR_LAST_BIT = 6'h17;
  localparam logic [5:0] PAGE_RD_DUMMY_LAST = 6'h1f;
  localparam logic [5:0] BUF_RD_DUMMY_LAST = 6'h07;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_LOWPWR = 8'h01;
  localparam logic [7:0] OP_READ_PAGE = 8'hd2;
  localparam logic [7:0] OP_BUF1_READ_HF = 8'hd4;
  localparam logic [7:0] OP_BUF1_READ_LF = 8'hd1;
  localparam logic [7:0] OP_BUF2_READ_HF = 8'hd6;
  localparam logic [7:0] OP_BUF2_READ_LF = 8'hd3;
  localparam logic [7:0] OP_BUF1_WRITE = 8'h84;
  localparam logic [7:0] OP_BUF2_WRITE = 8'h87;
  localparam logic [7:0] OP_BUF1_PGM_ERASE = 8'h83;
  localparam logic [7:0] OP_BUF2_PGM_ERASE = 8'h86;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bufSel;
    logic [11:0] page;
  } sfr_pgm_t;

  typedef struct packed {
    logic busy;
    logic eraseProgramErrorFlag;
  } sfr_status_t;

endpackage

// file: verification/sfr_host_model.sv
// host serial bus controller model: mode 0 frames, msb first
// assumes the device samples serIn on sclk rising and updates serOut on falling
`timescale 1ns/10ps
module sfr_host_model (
  // serial link
  output logic sclk,
  output logic csB,
  output logic serIn,
  input wire logic serOut,
  input wire logic serOutOeB
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    csB = 1'b1;
    serIn = 1'b1;
  end
  task automatic start();
    #3 csB = 1'b0;
  endtask
  // msb first shifting; sclk stands low outside frames, 80 ns period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serIn = tx[i];
      #20 sclk = 1'b1;
      rx[i] = serOutOeB ? ~serOut : serOut; // floating line never reads as data
      #40 sclk = 1'b0;
      #20;
    end
  endtask
  // released data line shows the inverse, not a stale bit
  task automatic stop();
    csB = 1'b1;
    serIn = ~serIn;
  endtask
endmodule

// file: verification/testbench.sv
// self-checking bench for the serial flash command core, 512-byte pages,
// then 528-byte pages after a second reset
// assumes the host model drives the link; core inputs move on falling edges
`timescale 1ns/10ps
module testbench;
  localparam int unsigned EpCyc = 2000;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic pageSize528 = 1'b0;
  logic sclk, csB, serIn, serOut, serOutOeB;
  sfr_pkg::sfr_status_t status;
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] pat [3] = '{8'h5a, 8'ha3, 8'h3c};
  logic [7:0] rx;
  logic [11:0] pages [4] = '{12'h003, 12'h004, 12'h000, 12'hfff};
  // 100 MHz core clock
  always #5 core_clk = ~core_clk;
  sfr_cmd_core #(.epCycles(EpCyc)) i_sfr_cmd_core (.core_clk(core_clk), .rst_b(rst_b),
    .pageSize528(pageSize528), .sclk(sclk), .csB(csB), .serIn(serIn), .serOut(serOut),
    .serOutOeB(serOutOeB), .status(status));
  sfr_host_model i_sfr_host_model (.sclk(sclk), .csB(csB), .serIn(serIn), .serOut(serOut),
    .serOutOeB(serOutOeB));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic head(input logic [7:0] op, input logic [23:0] addr, input int nd);
    i_sfr_host_model.start();
    i_sfr_host_model.xfer(op, rx);
    for (int i = 2; i >= 0; i--) i_sfr_host_model.xfer(addr[i*8+:8], rx);
    for (int i = 0; i < nd; i++) i_sfr_host_model.xfer(8'h00, rx);
  endtask
  task automatic tail();
    i_sfr_host_model.stop();
    #1;
    check({7'h00, serOutOeB}, 8'h01);
  endtask
  // three bytes read, xor mask tells the buffers apart
  task automatic rd(input logic [7:0] op, input logic [23:0] addr, input int nd,
                    input logic [7:0] inv);
    head(op, addr, nd);
    for (int k = 0; k < 3; k++) begin
      i_sfr_host_model.xfer(8'h00, rx);
      check(rx, pat[k] ^ inv);
    end
    tail();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // writes straddle the buffer end, second buffer gets the inverse
  task automatic t_buf_write();
    head(8'h84, {15'h0000, 9'h1fe}, 0);
    for (int k = 0; k < 3; k++) i_sfr_host_model.xfer(pat[k], rx);
    tail();
    head(8'h87, {15'h0000, 9'h1fe}, 0);
    for (int k = 0; k < 3; k++) i_sfr_host_model.xfer(~pat[k], rx);
    tail();
  endtask
  // every program is timed: busy must rise soon and last the set window;
  // spoil rewrites byte 0 of the second buffer between program and verify
  task automatic t_program(input logic [7:0] op, input logic [11:0] page, input logic spoil);
    int n;
    head(op, {3'h0, page, 9'h000}, 0);
    tail();
    n = 0;
    while (status.busy !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    check({7'h00, status.busy}, 8'h01);
    n = 0;
    fork
      while (status.busy === 1'b1 && n < EpCyc + 10) begin
        @(negedge core_clk);
        n++;
      end
      if (spoil) begin
        #4000;
        head(8'h87, 24'h000000, 0);
        i_sfr_host_model.xfer(8'h00, rx);
        tail();
      end
    join
    check({7'h00, n >= EpCyc && n <= EpCyc + 2}, 8'h01);
    check({7'h00, status.eraseProgramErrorFlag}, {7'h00, spoil});
    // put the spoiled byte back so later buffer reads still see the pattern
    if (spoil) begin
      head(8'h87, 24'h000000, 0);
      i_sfr_host_model.xfer(~pat[2], rx);
      tail();
    end
  endtask
  // page end rolls to next page, array end to page zero, page read stays
  task automatic t_array_read();
    rd(8'h01, {3'h0, 12'h003, 9'h1fe}, 0, 8'h00);
    rd(8'h01, {3'h0, 12'hfff, 9'h1fe}, 0, 8'h00);
    rd(8'hd2, {3'h0, 12'h003, 9'h1fe}, 4, 8'h00);
    rd(8'hd2, {3'h0, 12'h001, 9'h1fe}, 4, 8'hff);
  endtask
  // all four buffer read codes, run after array reads to see buffers intact
  task automatic t_buf_read();
    logic [7:0] ops [4] = '{8'hd4, 8'hd1, 8'hd6, 8'hd3};
    for (int i = 0; i < 4; i++) begin
      rd(ops[i], {15'h0000, 9'h1fe}, (i % 2 == 0) ? 1 : 0, (i > 1) ? 8'hff : 8'h00);
    end
  endtask
  // second reset into 528-byte pages: offsets past 1ffh are kept, wrap after 20fh
  task automatic t_page528();
    @(negedge core_clk);
    pageSize528 = 1'b1;
    rst_b = 1'b0;
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (5) @(negedge core_clk);
    check({6'h00, status}, 8'h00);
    head(8'h84, {14'h0000, 10'h20e}, 0);
    for (int k = 0; k < 3; k++) i_sfr_host_model.xfer(pat[k], rx);
    tail();
    rd(8'hd1, {14'h0000, 10'h20e}, 0, 8'h00);
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (5) @(negedge core_clk);
    t_buf_write();
    for (int i = 0; i < 4; i++) t_program(8'h83, pages[i], 1'b0);
    t_program(8'h86, 12'h001, 1'b1);
    t_array_read();
    t_buf_read();
    t_page528();
    finish_test();
  end
  // whole run takes about 0.2 ms; twice that means a hang
  initial begin
    #400000;
    num_errors++;
    finish_test();
  end
endmodule
